// ### carc_defs.svh
`ifndef CARC_DEFS_SVH
`define CARC_DEFS_SVH

// ------------------------------------------------------------
// register map (index printed, byte address is four times it)
// ------------------------------------------------------------
`define CARC_OSC_CTRL_IDX 10'h0DB
`define CARC_STATUS_IDX 10'h0DC
`define CARC_OSC_OFF_BIT 0
`define CARC_OSC_CTRL_RST 8'h00

// ------------------------------------------------------------
// dividers and counts
// ------------------------------------------------------------
`define CARC_TIMER_DIV 4'hC
`define CARC_CPU_DIV 4'hD
`define CARC_ADC_DIV_LO 4'h6
`define CARC_ADC_DIV_HI 4'hC
`define CARC_INSTR_SHORT 3'h2
`define CARC_INSTR_MID 3'h4
`define CARC_INSTR_LONG 3'h5
`define CARC_RST_DELAY_CYC 12'h800

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CARC_CLK_PERIOD_NS 50
`define CARC_SG_MIN_PERIOD_NS 125
`define CARC_SG_GAP_CYC \
    ((`CARC_SG_MIN_PERIOD_NS + `CARC_CLK_PERIOD_NS - 1) / `CARC_CLK_PERIOD_NS)

`endif

// ### carc_pkg.sv
package carc_pkg;

    typedef enum logic [1:0] {RS_HOLD, RS_DELAY, RS_RUN} carc_rst_e;
    typedef enum logic [1:0] {SRC_MAIN, SRC_ARM, SRC_BACKUP} carc_src_e;

    typedef struct packed {
        logic [2:0] rst_sync;
        logic [2:0] por_sync;
        logic [2:0] main_sync;
        logic ext_lvl;
        logic por_lvl;
        logic main_lvl;
        logic sg_en;
        logic osc_off;
        carc_rst_e rst_st;
        logic [11:0] dly_cnt;
        carc_src_e src;
        logic [7:0] miss_cnt;
        logic [7:0] bk_cnt;
        logic [3:0] gap_cnt;
        logic [3:0] t12_cnt;
        logic [3:0] c13_cnt;
        logic [3:0] adc_cnt;
        logic [2:0] mc_cnt;
        logic int_tick;
        logic timer_tick;
        logic cpu_cycle;
        logic adc_tick;
        logic instr_end;
        logic core_rst_b;
        logic io_pullup;
        logic main_osc_en;
        logic backup_run;
        logic wr_pend;
        logic wr_osc;
        logic [7:0] hrdata;
        logic hready;
    } carc_state_s;

endpackage

// ### carc_top.sv
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "carc_defs.svh"

module carc_top
    import carc_pkg::*;
#(
    parameter logic [7:0] BACKUP_DIV = 8'h32,
    parameter logic [7:0] MISS_LIMIT = 8'h10
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ext_rst_pin_b,
    input wire logic por_b,
    input wire logic wdg_timeout,
    input wire logic main_osc_in,
    input wire logic safeguard_enable_option,
    input wire logic cpu_stop,
    input wire logic adc_div_sel,
    input wire logic [1:0] instr_len_sel,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic int_tick,
    output logic timer_tick,
    output logic cpu_cycle,
    output logic adc_tick,
    output logic instr_end,
    output logic core_rst_b,
    output logic io_pullup,
    output logic main_osc_en,
    output logic backup_run
);

    localparam logic [3:0] GAP_CYC = 4'(`CARC_SG_GAP_CYC);
    localparam logic [11:0] DLY_LAST = `CARC_RST_DELAY_CYC - 12'h001;

    carc_state_s st_q;
    carc_state_s st_d;

    logic main_edge;
    logic bk_edge;
    logic bk_ok;
    logic missing;
    logic raw_edge;
    logic accept;
    logic rst_src;
    logic run;
    logic addr_ok;
    logic [9:0] idx;
    logic [3:0] adc_div;
    logic [2:0] instr_len;
    logic halt;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        // pins: a change counts once second and third stages agree
        st_d.rst_sync = {st_q.rst_sync[1:0], ext_rst_pin_b};
        st_d.por_sync = {st_q.por_sync[1:0], por_b};
        st_d.main_sync = {st_q.main_sync[1:0], main_osc_in};
        if (st_q.rst_sync[1] == st_q.rst_sync[2]) begin
            st_d.ext_lvl = st_q.rst_sync[2];
        end
        if (st_q.por_sync[1] == st_q.por_sync[2]) begin
            st_d.por_lvl = st_q.por_sync[2];
        end
        if (st_q.main_sync[1] == st_q.main_sync[2]) begin
            st_d.main_lvl = st_q.main_sync[2];
        end
        main_edge = st_d.main_lvl & ~st_q.main_lvl;
        run = (st_q.rst_st == RS_RUN);

        // backup may run with the option, or while still in reset
        bk_ok = st_q.sg_en | ~run;
        missing = (st_q.miss_cnt == MISS_LIMIT);
        if (main_edge) begin
            st_d.miss_cnt = 8'h00;
        end else if (!missing) begin
            st_d.miss_cnt = st_q.miss_cnt + 8'h01;
        end

        // backup oscillator modelled as a divider of the bus clock
        bk_edge = (st_q.bk_cnt == BACKUP_DIV - 8'h01);
        if (st_q.src == SRC_MAIN || bk_edge) begin
            st_d.bk_cnt = 8'h00;
        end else begin
            st_d.bk_cnt = st_q.bk_cnt + 8'h01;
        end
        unique case (st_q.src)
            SRC_MAIN: begin
                if (missing && bk_ok) begin
                    st_d.src = SRC_ARM;
                end
            end
            SRC_ARM: begin
                if (main_edge || !bk_ok) begin
                    st_d.src = SRC_MAIN;
                end else if (bk_edge) begin
                    st_d.src = SRC_BACKUP;
                end
            end
            SRC_BACKUP: begin
                if (main_edge || !bk_ok) begin
                    st_d.src = SRC_MAIN;
                end
            end
        endcase
        st_d.backup_run = (st_d.src != SRC_MAIN);

        raw_edge = (st_q.src == SRC_BACKUP) ? bk_edge :
                   ((st_q.src == SRC_MAIN) ? main_edge : 1'b0);
        // gap count survives a source change, so no short phase
        accept = raw_edge &
                 (~st_q.sg_en | (st_q.gap_cnt >= GAP_CYC));
        if (accept) begin
            st_d.gap_cnt = 4'h1;
        end else if (st_q.gap_cnt < GAP_CYC) begin
            st_d.gap_cnt = st_q.gap_cnt + 4'h1;
        end
        // stop freezes the clock on either source
        st_d.int_tick = accept & ~(cpu_stop & run);

        // reset sequencing
        rst_src = ~st_q.ext_lvl | ~st_q.por_lvl | wdg_timeout;
        unique case (st_q.rst_st)
            RS_HOLD: begin
                st_d.dly_cnt = 12'h000;
                st_d.sg_en = safeguard_enable_option;
                if (!rst_src) begin
                    st_d.rst_st = RS_DELAY;
                end
            end
            RS_DELAY: begin
                if (rst_src) begin
                    st_d.rst_st = RS_HOLD;
                end else if (st_q.int_tick) begin
                    st_d.dly_cnt = st_q.dly_cnt + 12'h001;
                    if (st_q.dly_cnt == DLY_LAST) begin
                        st_d.rst_st = RS_RUN;
                    end
                end
            end
            RS_RUN: begin
                if (rst_src) begin
                    st_d.rst_st = RS_HOLD;
                end
            end
        endcase
        st_d.core_rst_b = (st_d.rst_st == RS_RUN);
        st_d.io_pullup = ~st_d.core_rst_b;
        // halted from the very edge that enters reset, so no stale count
        halt = ~run | (st_d.rst_st != RS_RUN);

        // register bus, data phase write
        if (halt) begin
            st_d.osc_off = 1'b0;
        end else if (st_q.wr_pend && st_q.wr_osc) begin
            st_d.osc_off = hwdata[`CARC_OSC_OFF_BIT];
        end
        st_d.main_osc_en = ~(st_d.sg_en & st_d.osc_off) &
                           ~(cpu_stop & ~halt);

        // address phase, read data registered for the data phase
        addr_ok = hsel & htrans[1] & hready;
        idx = haddr[11:2];
        st_d.wr_pend = addr_ok & hwrite;
        st_d.wr_osc = (idx == `CARC_OSC_CTRL_IDX);
        st_d.hrdata = 8'h00;
        st_d.hready = 1'b1;
        if (addr_ok && !hwrite) begin
            if (idx == `CARC_OSC_CTRL_IDX) begin
                st_d.hrdata = {7'h00, st_d.osc_off};
            end else if (idx == `CARC_STATUS_IDX) begin
                st_d.hrdata = {4'h0, st_d.sg_en, st_d.main_osc_en,
                               st_d.backup_run, st_d.core_rst_b};
            end
        end

        // dividers run only while the core is out of reset
        adc_div = adc_div_sel ? `CARC_ADC_DIV_HI : `CARC_ADC_DIV_LO;
        unique case (instr_len_sel)
            2'h0: instr_len = `CARC_INSTR_SHORT;
            2'h1: instr_len = `CARC_INSTR_MID;
            default: instr_len = `CARC_INSTR_LONG;
        endcase
        st_d.timer_tick = 1'b0;
        st_d.cpu_cycle = 1'b0;
        st_d.adc_tick = 1'b0;
        st_d.instr_end = 1'b0;
        if (halt) begin
            st_d.t12_cnt = 4'h0;
            st_d.c13_cnt = 4'h0;
            st_d.adc_cnt = 4'h0;
            st_d.mc_cnt = 3'h0;
        end else begin
            if (st_q.int_tick) begin
                if (st_q.t12_cnt == `CARC_TIMER_DIV - 4'h1) begin
                    st_d.t12_cnt = 4'h0;
                    st_d.timer_tick = 1'b1;
                end else begin
                    st_d.t12_cnt = st_q.t12_cnt + 4'h1;
                end
                if (st_q.c13_cnt == `CARC_CPU_DIV - 4'h1) begin
                    st_d.c13_cnt = 4'h0;
                    st_d.cpu_cycle = 1'b1;
                end else begin
                    st_d.c13_cnt = st_q.c13_cnt + 4'h1;
                end
                if (st_q.adc_cnt >= adc_div - 4'h1) begin
                    st_d.adc_cnt = 4'h0;
                    st_d.adc_tick = 1'b1;
                end else begin
                    st_d.adc_cnt = st_q.adc_cnt + 4'h1;
                end
            end
            if (st_q.cpu_cycle) begin
                if (st_q.mc_cnt >= instr_len - 3'h1) begin
                    st_d.mc_cnt = 3'h0;
                    st_d.instr_end = 1'b1;
                end else begin
                    st_d.mc_cnt = st_q.mc_cnt + 3'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '0;
            st_q.io_pullup <= 1'b1;
            st_q.main_osc_en <= 1'b1;
            st_q.hready <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign hrdata = {24'h000000, st_q.hrdata};
    assign hreadyout = st_q.hready;
    assign hresp = 1'b0;
    assign int_tick = st_q.int_tick;
    assign timer_tick = st_q.timer_tick;
    assign cpu_cycle = st_q.cpu_cycle;
    assign adc_tick = st_q.adc_tick;
    assign instr_end = st_q.instr_end;
    assign core_rst_b = st_q.core_rst_b;
    assign io_pullup = st_q.io_pullup;
    assign main_osc_en = st_q.main_osc_en;
    assign backup_run = st_q.backup_run;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);

    sequence s_miss;
        st_q.src == SRC_MAIN && st_q.miss_cnt == MISS_LIMIT && bk_ok;
    endsequence

    sequence s_arm_done;
        st_q.src == SRC_ARM && bk_edge && !main_edge && bk_ok;
    endsequence

    a_osc_off_stop: assert property (
        st_q.sg_en && st_q.osc_off |-> !st_q.main_osc_en)
        else $error("main oscillator enabled while off bit set");
    a_backup_arm: assert property (
        s_miss |=> st_q.src == SRC_ARM)
        else $error("backup not armed after missing edge");
    a_backup_off: assert property (
        st_q.src == SRC_BACKUP && main_edge && bk_ok
        |=> st_q.src == SRC_MAIN && !st_q.backup_run)
        else $error("backup still running after main edge");
    a_gap_limit: assert property (
        st_q.int_tick && st_q.sg_en |=> !st_q.int_tick [*2])
        else $error("internal clock above safeguard maximum");
    a_pin_hold: assert property (
        !st_q.ext_lvl |=> !st_q.core_rst_b ##1 !st_q.core_rst_b)
        else $error("core left reset while pin low");
    a_release_count: assert property (
        $rose(st_q.core_rst_b) |-> $past(st_q.dly_cnt) == DLY_LAST)
        else $error("reset released before full delay");
    a_io_pullup: assert property (
        !st_q.core_rst_b |-> st_q.io_pullup && st_q.mc_cnt == 3'h0)
        else $error("outputs not pulled up during reset");
    a_wdg_reset: assert property (
        wdg_timeout |=> st_q.rst_st == RS_HOLD ##1 !st_q.core_rst_b)
        else $error("watchdog timeout did not reset");
    a_osc_restart: assert property (
        st_q.rst_st != RS_RUN |=> !st_q.osc_off)
        else $error("reset did not restart main oscillator");
    a_no_backup: assert property (
        !st_q.sg_en && st_q.rst_st == RS_RUN && st_q.src == SRC_MAIN
        |=> st_q.src == SRC_MAIN)
        else $error("backup entered with safeguard disabled");
    a_arm_backup: assert property (
        s_arm_done |=> st_q.src == SRC_BACKUP && st_q.backup_run)
        else $error("backup did not start after one period");
    a_stop_gate: assert property (
        cpu_stop && st_q.rst_st == RS_RUN |=> !st_q.int_tick)
        else $error("internal clock ran in stop mode");
    a_halt_ticks: assert property (
        !st_q.core_rst_b |-> !st_q.timer_tick && !st_q.cpu_cycle)
        else $error("core clocks ran during reset");

endmodule
`default_nettype wire

// ### carc_board_model.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// board side: crystal and reset circuit
// ------------------------------------------------------------
module carc_board_model (
    input wire logic osc_enable,
    input wire logic osc_kill,
    input wire logic osc_fast,
    input wire logic pin_low,
    input wire logic power_low,
    output logic main_osc_in,
    output logic ext_rst_pin_b,
    output logic por_b
);
    // pin has a pull-up, so it idles high unless pulled down
    assign ext_rst_pin_b = !pin_low;
    assign por_b = !power_low;
    initial begin
        main_osc_in = 1'b0;
        forever begin
            // steps land on falling clock edges, clear of sampling;
            // the fast rate flips every clock, which the pin filter
            // has to treat as spikes
            #(osc_fast ? 50 : 100);
            // a stopped or dead crystal sits still at low
            main_osc_in = (osc_enable && !osc_kill) ? !main_osc_in : 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### carc_top_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "carc_defs.svh"
module carc_top_bench;
    localparam logic [31:0] A_OSC = 32'(`CARC_OSC_CTRL_IDX) << 2;
    localparam logic [31:0] A_STAT = 32'(`CARC_STATUS_IDX) << 2;
    localparam int DLY = `CARC_RST_DELAY_CYC;
    logic clock, rst_b, wdg_timeout, sg_opt, cpu_stop, adc_div_sel;
    logic [1:0] instr_len_sel, htrans;
    logic hsel, hwrite, pin_low, power_low, kill, fast;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [2:0] hsize;
    logic hreadyout, hresp, int_tick, timer_tick, cpu_cycle, adc_tick;
    logic instr_end, core_rst_b, io_pullup, main_osc_en, backup_run;
    wire logic main_osc_in, ext_rst_pin_b, por_b;
    logic [2:0] il[4] = '{`CARC_INSTR_SHORT, `CARC_INSTR_MID,
                          `CARC_INSTR_LONG, `CARC_INSTR_LONG};
    int fails, total_checks, n, m;

    // short counts keep the run brief; a backup edge every two clocks
    // is faster than the safeguard allows, so it must drop cycles
    carc_top #(.BACKUP_DIV(8'h02), .MISS_LIMIT(8'h06)) i_dut (
        .clock(clock), .rst_b(rst_b), .ext_rst_pin_b(ext_rst_pin_b),
        .por_b(por_b), .wdg_timeout(wdg_timeout), .main_osc_in(main_osc_in),
        .safeguard_enable_option(sg_opt), .cpu_stop(cpu_stop),
        .adc_div_sel(adc_div_sel), .instr_len_sel(instr_len_sel),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .int_tick(int_tick), .timer_tick(timer_tick), .cpu_cycle(cpu_cycle),
        .adc_tick(adc_tick), .instr_end(instr_end), .core_rst_b(core_rst_b),
        .io_pullup(io_pullup), .main_osc_en(main_osc_en),
        .backup_run(backup_run));

    carc_board_model i_board (.osc_enable(main_osc_en), .osc_kill(kill),
        .osc_fast(fast), .pin_low(pin_low), .power_low(power_low),
        .main_osc_in(main_osc_in), .ext_rst_pin_b(ext_rst_pin_b),
        .por_b(por_b));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic end_of_test();
        if (fails == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic pick(input int k);
        case (k)
            0: pick = int_tick;
            1: pick = timer_tick;
            2: pick = cpu_cycle;
            3: pick = adc_tick;
            4: pick = instr_end;
            5: pick = core_rst_b;
            6: pick = backup_run;
            7: pick = main_osc_en;
            default: pick = hreadyout;
        endcase
    endfunction

    task automatic wt(input int k, input logic v, input int bound);
        for (int i = 0; i < bound; i++) begin
            @(posedge clock);
            if (pick(k) === v) begin
                total_checks++;
                return;
            end
        end
        fails++;
        $display("[FAIL] %0t wait on signal %0d timed out", $time, k);
        end_of_test();
    endtask

    task automatic bus(input logic [31:0] a, input logic w,
                       input logic [31:0] d);
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        wt(8, 1'b1, 20);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wt(8, 1'b1, 20);
        q = hrdata;
        chk(32'(hresp), 32'h0);
    endtask

    // counts source pulses between two event pulses
    task automatic meas(input int s, input int e, output int c);
        int i;
        repeat (2) begin
            wt(e, 1'b1, 2000);
            c = 0;
            i = 0;
            do begin
                @(posedge clock);
                c += int'(pick(s) === 1'b1);
                i++;
            end while (pick(e) !== 1'b1 && i < 2000);
            if (pick(e) !== 1'b1) begin
                fails++;
                end_of_test();
            end
        end
    endtask

    task automatic cnt(output int t, output int c);
        t = 0;
        c = 0;
        for (int i = 0; i < 20000; i++) begin
            @(posedge clock);
            if (core_rst_b === 1'b1) begin
                return;
            end
            t += int'(int_tick === 1'b1);
            c += int'(cpu_cycle === 1'b1);
        end
        fails++;
        end_of_test();
    endtask

    task automatic rng(input int v);
        chk(32'(v >= DLY - 2 && v <= DLY + 2), 32'h1);
    endtask

    task automatic gap(output int g);
        int c;
        g = 99;
        wt(0, 1'b1, 50);
        for (int j = 0; j < 30; j++) begin
            c = 0;
            do begin
                @(posedge clock);
                c++;
            end while (int_tick !== 1'b1 && c < 50);
            if (int_tick !== 1'b1) begin
                fails++;
                end_of_test();
            end
            if (c < g) g = c;
        end
    endtask

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        {rst_b, wdg_timeout, cpu_stop, adc_div_sel, hsel, hwrite} = '0;
        {htrans, haddr, hwdata, instr_len_sel} = '0;
        hsize = 3'h2;
        {sg_opt, power_low, kill, pin_low, fast} = 5'b11100;
        fails = 0;
        total_checks = 0;
        repeat (3) @(posedge clock);
        chk({27'h0, core_rst_b, io_pullup, main_osc_en, backup_run,
             hreadyout}, 32'h0000000D);
        rst_b <= 1'b1;
        repeat (20) @(posedge clock);
        chk(32'(core_rst_b), 32'h0);
        power_low <= 1'b0;
        wt(6, 1'b1, 200);
        cnt(n, m);
        rng(n);
        chk(32'(m), 32'h0);
        kill <= 1'b0;
        wt(6, 1'b0, 200);
        meas(0, 1, n);
        chk(32'(n), 32'(`CARC_TIMER_DIV));
        meas(0, 2, n);
        chk(32'(n), 32'(`CARC_CPU_DIV));
        meas(0, 3, n);
        chk(32'(n), 32'(`CARC_ADC_DIV_LO));
        adc_div_sel <= 1'b1;
        meas(0, 3, n);
        chk(32'(n), 32'(`CARC_ADC_DIV_HI));
        for (int k = 0; k < 4; k++) begin
            instr_len_sel <= 2'(k);
            meas(2, 4, n);
            chk(32'(n), 32'(il[k]));
        end
        fast <= 1'b1;
        gap(n);
        chk(32'(n >= `CARC_SG_GAP_CYC), 32'h1);
        fast <= 1'b0;
        bus(A_OSC, 1'b1, 32'h1);
        wt(7, 1'b0, 10);
        wt(6, 1'b1, 100);
        bus(A_OSC, 1'b0, 32'h0);
        chk(q, 32'h1);
        bus(A_STAT, 1'b0, 32'h0);
        chk(q, 32'h0000000B);
        meas(0, 1, n);
        chk(32'(n), 32'(`CARC_TIMER_DIV));
        bus(32'h0, 1'b0, 32'h0);
        chk(q, 32'h0);
        bus(A_OSC, 1'b1, 32'h0);
        wt(7, 1'b1, 10);
        wt(6, 1'b0, 100);
        kill <= 1'b1;
        wt(6, 1'b1, 100);
        kill <= 1'b0;
        wt(6, 1'b0, 100);
        bus(A_OSC, 1'b1, 32'h1);
        wt(7, 1'b0, 10);
        wdg_timeout <= 1'b1;
        @(posedge clock);
        wdg_timeout <= 1'b0;
        wt(5, 1'b0, 5);
        chk(32'(io_pullup), 32'h1);
        wt(7, 1'b1, 5);
        cnt(n, m);
        rng(n);
        chk(32'(m), 32'h0);
        bus(A_OSC, 1'b0, 32'h0);
        chk(q, 32'h0);
        cpu_stop <= 1'b1;
        repeat (10) @(posedge clock);
        pin_low <= 1'b1;
        wt(5, 1'b0, 10);
        repeat (40) @(posedge clock);
        chk({29'h0, io_pullup, main_osc_en, core_rst_b},
            32'h6);
        cpu_stop <= 1'b0;
        pin_low <= 1'b0;
        cnt(n, m);
        rng(n);
        pin_low <= 1'b1;
        repeat (3) @(posedge clock);
        pin_low <= 1'b0;
        wt(5, 1'b0, 10);
        cnt(n, m);
        rng(n);
        sg_opt <= 1'b0;
        pin_low <= 1'b1;
        wt(5, 1'b0, 10);
        pin_low <= 1'b0;
        cnt(n, m);
        rng(n);
        bus(A_OSC, 1'b1, 32'h1);
        repeat (5) @(posedge clock);
        chk(32'(main_osc_en), 32'h1);
        kill <= 1'b1;
        repeat (40) @(posedge clock);
        chk(32'(backup_run), 32'h0);
        bus(A_STAT, 1'b0, 32'h0);
        chk(q, 32'h00000005);
        end_of_test();
    end
endmodule
`default_nettype wire
